// File: ctt_pkg.sv
// Constants, field layout and carrier types of the compact 10-bit timer.
// Assumes a single 100 MHz clock that also stands in for the high clock.
`default_nettype none
package ctt_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SUB_HZ = 32768;
  localparam int unsigned SUB_DIV = CLK_HZ / SUB_HZ;
  localparam logic [11:0] SUB_LAST = 12'(SUB_DIV - 1);
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [2:0] OFS_CTRL0 = 3'h0;
  localparam logic [2:0] OFS_CTRL1 = 3'h1;
  localparam logic [2:0] OFS_CNT_LO = 3'h2;
  localparam logic [2:0] OFS_CNT_HI = 3'h3;
  localparam logic [2:0] OFS_CMPA_LO = 3'h4;
  localparam logic [2:0] OFS_CMPA_HI = 3'h5;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int C0_PAU = 7;
  localparam int C0_CK_LSB = 4;
  localparam int C0_ON = 3;
  localparam int C0_RP_LSB = 0;
  localparam int C1_MODE_LSB = 6;
  localparam int C1_IO_LSB = 4;
  localparam int C1_OC = 3;
  localparam int C1_POL = 2;
  localparam int C1_DPX = 1;
  localparam int C1_CCLR = 0;
  localparam int CNT_W = 10;
  localparam int P_LSB = 7;
  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_HI_DIV16 = 3'h2;
  localparam logic [2:0] CK_HI_DIV64 = 3'h3;
  localparam logic [2:0] CK_SUB_A = 3'h4;
  localparam logic [2:0] CK_SUB_B = 3'h5;
  localparam logic [2:0] CK_EXT_RISE = 3'h6;
  localparam logic [2:0] CK_EXT_FALL = 3'h7;
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] IO_NONE = 2'h0;
  localparam logic [1:0] IO_LOW = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
  localparam logic [1:0] IO_PWM = 2'h2;
  // ****************************************
  // Types
  // ****************************************
  typedef logic [7:0] ctt_byte_t;
  typedef struct packed {
    logic [2:0] addr;
    ctt_byte_t wdata;
    logic wr;
    logic rd;
  } ctt_bus_req_s;
  typedef struct packed {
    ctt_byte_t ctrl0;
    ctt_byte_t ctrl1;
    logic [CNT_W-1:0] compare_a_value;
    logic [CNT_W-1:0] cnt;
    ctt_byte_t lo_buf;
    ctt_byte_t rdata;
    logic en_d;
    logic [5:0] pre;
    logic [11:0] sub;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic ext_lvl;
    logic out_raw;
    logic pin;
    logic pin_b;
    logic int_a;
    logic int_p;
  } ctt_state_s;
endpackage
`default_nettype wire

// File: ctt_top.sv
// Compact 10-bit count-up timer with comparators A and P, output pin pair
// and a byte-wide register port. Assumes one 100 MHz clock, a master that
// never issues read and write strobes together, and an asynchronous
// external clock pin.
//
// Functional notes
// - Separate interrupt pulses for A and P matches
// - External clock edge selectable rising or falling
// - External pin can clock counter for events
// - Second output pin is inverse of first
// - Compare mode: match sets, clears or toggles output
// - PWM drives the same output pin pair
// - Low bytes move only on high-byte access
// - Low write buffers; high write commits both bytes
// - High read latches low byte into buffer
// - Ten-bit up-counter on internal or external clock
// - P compares top three bits; A all
// - Counter also cleared by enable rising edge
// - Counter clears on overflow or selected match
// - Compare, timer/counter and PWM modes
// - Counter read-only pair; compare A read/write pair
// - Counter high byte bits 1:0 hold bits 9:8
// - Counter high byte bits 7:2 read zero
// - Clock select picks prescaled, sub or pin clock
// - Enable rise clears counter; in compare mode it restores output
// - P value steps of 128, zero means 1024
// - Mode field: 00 compare, 10 PWM, 11 timer
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ctt_top
  import ctt_pkg::*;
(
  input wire logic MCLK_IN,                        // System clock
  input wire logic RST_B_IN,                       // Sync reset, low
  input wire ctt_pkg::ctt_bus_req_s BUS_REQ_IN,    // Register request
  input wire logic EXT_CLK_PIN_IN,                 // External clock pin
  output logic [7:0] RD_DATA_OUT,                  // Read data, +1 cycle
  output logic TMR_OUT_PIN_OUT,                    // Timer output pin
  output logic TMR_OUT_INV_PIN_OUT,                // Inverted output pin
  output logic INT_A_OUT,                          // Compare A pulse
  output logic INT_P_OUT                           // Compare P pulse
);
  import ctt_pkg::*;

  // ****************************************
  // State and decoded fields
  // ****************************************
  ctt_state_s st_ff;
  ctt_state_s nxt_st;

  logic pau;
  logic [2:0] ck_sel;
  logic en;
  logic [2:0] rp;
  logic [1:0] mode;
  logic [1:0] io;
  logic oc;
  logic pol;
  logic dpx;
  logic cclr;
  logic ext_rise;
  logic ext_fall;
  logic tick;
  logic run;
  logic en_rise;
  logic ovf;
  logic [CNT_W-1:0] cnt_inc;
  logic p_hit;
  logic a_hit;
  logic clr_hit;
  logic [CNT_W-1:0] cnt_new;
  logic [CNT_W-1:0] duty;
  logic raw_new;
  logic pin_new;

  // True when the low n bits of the prescaler are all ones
  function automatic logic pre_full(input logic [5:0] v, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      if (i < n)
      begin
        r = r & v[i];
      end
    end
    return r;
  endfunction

  // Upper register byte of a count; bits 7:2 are unused and read zero
  function automatic ctt_byte_t hi_byte(input logic [CNT_W-1:0] v);
    ctt_byte_t r;
    r = 8'h00;
    r[1:0] = v[CNT_W-1:CNT_W-2];
    return r;
  endfunction

  // Filtered pin edge towards lvl, once stages two and three agree
  function automatic logic pin_edge(input logic s2, input logic s3,
                                    input logic held, input logic lvl);
    return (s2 == s3) && (s3 == lvl) && (held != lvl);
  endfunction

  assign pau = st_ff.ctrl0[C0_PAU];
  assign ck_sel = st_ff.ctrl0[C0_CK_LSB +: 3];
  assign en = st_ff.ctrl0[C0_ON];
  assign rp = st_ff.ctrl0[C0_RP_LSB +: 3];
  assign mode = st_ff.ctrl1[C1_MODE_LSB +: 2];
  assign io = st_ff.ctrl1[C1_IO_LSB +: 2];
  assign oc = st_ff.ctrl1[C1_OC];
  assign pol = st_ff.ctrl1[C1_POL];
  assign dpx = st_ff.ctrl1[C1_DPX];
  assign cclr = st_ff.ctrl1[C1_CCLR];

  // ****************************************
  // Clock source selection
  // ****************************************
  // A pin change counts once the second and third stages agree on it
  // A glitch shorter than one clock never reaches the counter
  assign ext_rise = pin_edge(st_ff.ext_s2, st_ff.ext_s3, st_ff.ext_lvl,
                             1'b1);
  assign ext_fall = pin_edge(st_ff.ext_s2, st_ff.ext_s3, st_ff.ext_lvl,
                             1'b0);

  always_comb
  begin
    case (ck_sel)
      CK_SYS_DIV4: tick = pre_full(st_ff.pre, 2);
      CK_SYS: tick = 1'b1;
      CK_HI_DIV16: tick = pre_full(st_ff.pre, 4);
      CK_HI_DIV64: tick = pre_full(st_ff.pre, 6);
      CK_SUB_A: tick = (st_ff.sub == SUB_LAST);
      CK_SUB_B: tick = (st_ff.sub == SUB_LAST);
      CK_EXT_RISE: tick = ext_rise;
      CK_EXT_FALL: tick = ext_fall;
      default: tick = 1'b0;
    endcase
  end

  // ****************************************
  // Counter and comparators
  // ****************************************
  // The prescaler runs free, so the first prescaled tick after enable
  // may come early by up to one prescaler period; the match spacing
  // after that first tick is exact.
  assign en_rise = en & ~st_ff.en_d;
  assign run = en & ~pau & tick;
  assign cnt_inc = st_ff.cnt + 10'h001;
  assign ovf = &st_ff.cnt;

  // P value zero stands for a full 1024-count period
  always_comb
  begin
    if (rp == 3'h0)
    begin
      p_hit = ovf;
    end
    else
    begin
      p_hit = (cnt_inc[CNT_W-1:P_LSB] == rp) &&
              (cnt_inc[P_LSB-1:0] == 7'h00);
    end
  end

  // A value zero is reached when the counter wraps
  always_comb
  begin
    if (st_ff.compare_a_value == 10'h000)
    begin
      a_hit = ovf;
    end
    else
    begin
      a_hit = (cnt_inc == st_ff.compare_a_value);
    end
  end

  // PWM takes its period from the swap bit, other modes from clear select
  always_comb
  begin
    if (mode == MODE_PWM)
    begin
      clr_hit = dpx ? a_hit : p_hit;
    end
    else
    begin
      clr_hit = cclr ? a_hit : p_hit;
    end
  end

  always_comb
  begin
    if (en_rise)
    begin
      cnt_new = 10'h000;
    end
    else if (run && (clr_hit || ovf))
    begin
      cnt_new = 10'h000;
    end
    else if (run)
    begin
      cnt_new = cnt_inc;
    end
    else
    begin
      cnt_new = st_ff.cnt;
    end
  end

  // ****************************************
  // Output waveform
  // ****************************************
  assign duty = dpx ? {rp, 7'h00} : st_ff.compare_a_value;

  always_comb
  begin
    raw_new = st_ff.out_raw;
    case (mode)
      MODE_CMP:
      begin
        if (en_rise)
        begin
          raw_new = oc;
        end
        else if (run && a_hit)
        begin
          case (io)
            IO_LOW: raw_new = 1'b0;
            IO_HIGH: raw_new = 1'b1;
            IO_TOGGLE: raw_new = ~st_ff.out_raw;
            default: raw_new = st_ff.out_raw;
          endcase
        end
      end
      MODE_TMR:
      begin
        // Timer mode keeps the output register as it stood
        raw_new = st_ff.out_raw;
      end
      MODE_PWM:
      begin
        // Active level is the initial-level bit; active while below duty
        case (io)
          IO_LOW: raw_new = oc;
          IO_PWM: raw_new = (cnt_new < duty) ? oc : ~oc;
          default: raw_new = ~oc;
        endcase
      end
      default: raw_new = st_ff.out_raw;
    endcase
  end

  // Timer mode leaves the pins frozen; polarity has no effect there
  always_comb
  begin
    if ((mode == MODE_CMP) || (mode == MODE_PWM))
    begin
      pin_new = raw_new ^ pol;
    end
    else
    begin
      pin_new = st_ff.pin;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.pre = st_ff.pre + 6'h01;
    nxt_st.sub = (st_ff.sub == SUB_LAST) ? 12'h000 : st_ff.sub + 12'h001;
    nxt_st.ext_s1 = EXT_CLK_PIN_IN;
    nxt_st.ext_s2 = st_ff.ext_s1;
    nxt_st.ext_s3 = st_ff.ext_s2;
    if (st_ff.ext_s2 == st_ff.ext_s3)
    begin
      nxt_st.ext_lvl = st_ff.ext_s3;
    end
    nxt_st.en_d = en;
    nxt_st.cnt = cnt_new;
    nxt_st.out_raw = raw_new;
    nxt_st.pin = pin_new;
    nxt_st.pin_b = ~pin_new;
    // Matches are judged only on a timer tick, so each is one pulse
    nxt_st.int_a = run & a_hit;
    nxt_st.int_p = run & p_hit;
    // Read data stand for one cycle only, then fall back to zero
    nxt_st.rdata = 8'h00;
    // Write wins should a master ever raise both strobes together
    if (BUS_REQ_IN.wr)
    begin
      case (BUS_REQ_IN.addr)
        OFS_CTRL0: nxt_st.ctrl0 = BUS_REQ_IN.wdata;
        OFS_CTRL1: nxt_st.ctrl1 = BUS_REQ_IN.wdata;
        // Low write only reaches the shared buffer
        OFS_CMPA_LO: nxt_st.lo_buf = BUS_REQ_IN.wdata;
        OFS_CMPA_HI:
        begin
          nxt_st.compare_a_value = {BUS_REQ_IN.wdata[1:0], st_ff.lo_buf};
        end
        // Counter bytes have no write path
        default: nxt_st.lo_buf = st_ff.lo_buf;
      endcase
    end
    else if (BUS_REQ_IN.rd)
    begin
      case (BUS_REQ_IN.addr)
        OFS_CTRL0: nxt_st.rdata = st_ff.ctrl0;
        OFS_CTRL1: nxt_st.rdata = st_ff.ctrl1;
        OFS_CNT_HI:
        begin
          nxt_st.rdata = hi_byte(st_ff.cnt);
          nxt_st.lo_buf = st_ff.cnt[7:0];
        end
        OFS_CMPA_HI:
        begin
          nxt_st.rdata = hi_byte(st_ff.compare_a_value);
          nxt_st.lo_buf = st_ff.compare_a_value[7:0];
        end
        // Out-of-order access returns whatever the buffer holds
        OFS_CNT_LO: nxt_st.rdata = st_ff.lo_buf;
        OFS_CMPA_LO: nxt_st.rdata = st_ff.lo_buf;
        default: nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_B_IN)
    begin
      st_ff <= '0;
      st_ff.ctrl0 <= RST_BYTE;
      st_ff.ctrl1 <= RST_BYTE;
      st_ff.pin_b <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign RD_DATA_OUT = st_ff.rdata;
  assign TMR_OUT_PIN_OUT = st_ff.pin;
  assign TMR_OUT_INV_PIN_OUT = st_ff.pin_b;
  assign INT_A_OUT = st_ff.int_a;
  assign INT_P_OUT = st_ff.int_p;

endmodule
`default_nettype wire

// File: ctt_ext_src.sv
// Pulse source standing in for the external clock pin of the timer.
// Assumes the bench raises go for one cycle with the pulse count beside it.
`timescale 1ns/1ps
`default_nettype none
module ctt_ext_src
(
  input wire logic clk_in,         // Bench clock
  input wire logic rst_b_in,       // Sync reset, low
  input wire logic [3:0] pulses_in, // Pulses to emit
  input wire logic go_in,          // Start, one cycle
  output logic pin_out             // Pin drive
);
  logic [3:0] left_ff;
  logic [3:0] ph_ff;
  // Slow 16-cycle pulses so the design's pin filter sees every edge
  assign pin_out = (left_ff != 4'h0) && ph_ff[3];
  always_ff @(posedge clk_in)
  begin
    ph_ff <= ph_ff + 4'h1;
    if (!rst_b_in || go_in)
    begin
      left_ff <= rst_b_in ? pulses_in : 4'h0;
      ph_ff <= 4'h0;
    end
    else if (left_ff != 4'h0 && ph_ff == 4'hf)
      left_ff <= left_ff - 4'h1;
  end
endmodule
`default_nettype wire

// File: ctt_top_sva.sv
// Port-level assertions of the compact timer.
// Assumes the master never raises read and write strobes together.
`timescale 1ns/1ps
`default_nettype none
module ctt_sva
  import ctt_pkg::*;
(
  input wire logic MCLK_IN,                     // Clock
  input wire logic RST_B_IN,                    // Reset, low
  input wire ctt_pkg::ctt_bus_req_s BUS_REQ_IN, // Request
  input wire logic EXT_CLK_PIN_IN,              // External pin
  input wire logic [7:0] RD_DATA_OUT,           // Read data
  input wire logic TMR_OUT_PIN_OUT,             // Output pin
  input wire logic TMR_OUT_INV_PIN_OUT,         // Inverted pin
  input wire logic INT_A_OUT,                   // A pulse
  input wire logic INT_P_OUT                    // P pulse
);
  wire logic wr = BUS_REQ_IN.wr;
  wire logic rd = BUS_REQ_IN.rd;
  wire logic [2:0] ad = BUS_REQ_IN.addr;
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_B_IN);
  property p_inv;
    TMR_OUT_INV_PIN_OUT == !TMR_OUT_PIN_OUT;
  endproperty
  a_inv: assert property (p_inv)
    else $error("inverted pin equals pin");
  property p_rd_idle;
    !rd |=> RD_DATA_OUT == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data without read");
  property p_cnt_hi;
    rd && ad == OFS_CNT_HI |=> RD_DATA_OUT[7:2] == 6'h00;
  endproperty
  a_cnt_hi: assert property (p_cnt_hi)
    else $error("counter high byte upper bits set");
  property p_cmpa_hi;
    wr && ad == OFS_CMPA_HI ##1 rd && ad == OFS_CMPA_HI
      |=> RD_DATA_OUT == {6'h00, $past(BUS_REQ_IN.wdata[1:0], 2)};
  endproperty
  a_cmpa_hi: assert property (p_cmpa_hi)
    else $error("compare high byte readback wrong");
  property p_pair;
    wr && ad == OFS_CMPA_LO ##1 wr && ad == OFS_CMPA_HI
      ##1 rd && ad == OFS_CMPA_HI ##1 rd && ad == OFS_CMPA_LO
      |=> RD_DATA_OUT == $past(BUS_REQ_IN.wdata, 4);
  endproperty
  a_pair: assert property (p_pair)
    else $error("compare low byte via buffer wrong");
  property p_ctrl;
    wr && ad == OFS_CTRL1 ##1 rd && ad == OFS_CTRL1
      |=> RD_DATA_OUT == $past(BUS_REQ_IN.wdata, 2);
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control readback wrong");
  property p_off;
    wr && ad == OFS_CTRL0 && !BUS_REQ_IN.wdata[C0_ON] ##1 (!wr)[*7]
      |-> !INT_A_OUT && !INT_P_OUT;
  endproperty
  a_off: assert property (p_off)
    else $error("match while counter off");
  property p_refuse;
    rd && ad[2:1] == 2'h3 |=> RD_DATA_OUT == 8'h00;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("unmapped read not zero");
  c_a: cover property ($rose(INT_A_OUT));
  c_p: cover property ($rose(INT_P_OUT));
  c_pin: cover property ($rose(TMR_OUT_PIN_OUT));
endmodule
bind ctt_top ctt_sva i_ctt_sva(.MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN),
  .BUS_REQ_IN(BUS_REQ_IN), .EXT_CLK_PIN_IN(EXT_CLK_PIN_IN),
  .RD_DATA_OUT(RD_DATA_OUT), .TMR_OUT_PIN_OUT(TMR_OUT_PIN_OUT),
  .TMR_OUT_INV_PIN_OUT(TMR_OUT_INV_PIN_OUT), .INT_A_OUT(INT_A_OUT),
  .INT_P_OUT(INT_P_OUT));
`default_nettype wire

// File: tb_ctt_top.sv
// Self-checking bench of the compact timer with an external pulse source.
// Assumes the bind in the checker file attaches the assertions.
`timescale 1ns/1ps
`default_nettype none
module tb_ctt_top;
  import ctt_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  ctt_bus_req_s req = '0;
  logic [3:0] np = 4'h0;
  logic go = 1'b0;
  wire logic ext;
  logic [7:0] rd_data;
  logic pin, pin_b, int_a, int_p;
  int fails = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  ctt_ext_src i_ctt_ext_src(.clk_in(clk), .rst_b_in(rst_b),
    .pulses_in(np), .go_in(go), .pin_out(ext));
  ctt_top i_ctt_top(.MCLK_IN(clk), .RST_B_IN(rst_b), .BUS_REQ_IN(req),
    .EXT_CLK_PIN_IN(ext), .RD_DATA_OUT(rd_data), .TMR_OUT_PIN_OUT(pin),
    .TMR_OUT_INV_PIN_OUT(pin_b), .INT_A_OUT(int_a), .INT_P_OUT(int_p));
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task tally_and_finish;
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request per edge; sampling 1 ns later avoids edge races
  task op(input logic w, input logic r, input logic [2:0] a,
          input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
    #1;
  endtask
  task rdc(input logic [2:0] a, input logic [7:0] exp);
    op(0, 1, a, 8'h00);
    op(0, 0, 3'h0, 8'h00);
    chk(rd_data, exp);
  endtask
  // Edges after the call's first edge until the chosen pulse, bounded
  task cyc_to(input bit p, output int n);
    n = 0;
    op(0, 0, 3'h0, 8'h00);
    while ((p ? int_p : int_a) !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 3000)
    begin
      fails++;
      tally_and_finish;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task s_regs;
    for (int a = 0; a < 8; a++)
      rdc(a[2:0], 8'h00);
  endtask
  task s_pair;
    op(1, 0, OFS_CMPA_LO, 8'ha5);
    op(1, 0, OFS_CMPA_HI, 8'hfe);
    op(0, 1, OFS_CMPA_HI, 8'h00);
    op(0, 1, OFS_CMPA_LO, 8'h00);
    chk(rd_data, 8'h02);
    op(0, 0, 3'h0, 8'h00);
    chk(rd_data, 8'ha5);
    op(1, 0, OFS_CNT_LO, 8'hff);
    op(1, 0, OFS_CNT_HI, 8'h03);
    rdc(OFS_CNT_HI, 8'h00);
    rdc(OFS_CNT_LO, 8'h00);
  endtask
  task s_cmp;
    int n;
    op(1, 0, OFS_CMPA_LO, 8'h05);
    op(1, 0, OFS_CMPA_HI, 8'h00);
    op(1, 0, OFS_CTRL1, 8'h31);
    op(1, 0, OFS_CTRL0, 8'h18);
    cyc_to(0, n);
    chk({7'h0, pin}, 8'h01);
    chk({7'h0, pin_b}, 8'h00);
    cyc_to(0, n);
    chk(8'(n), 8'h04);
    chk({7'h0, pin}, 8'h00);
    chk({7'h0, pin_b}, 8'h01);
    op(1, 0, OFS_CTRL0, 8'h10);
    repeat (8) op(0, 0, 3'h0, 8'h00);
    op(1, 0, OFS_CTRL1, 8'h39);
    op(1, 0, OFS_CTRL0, 8'h18);
    op(0, 0, 3'h0, 8'h00);
    op(0, 0, 3'h0, 8'h00);
    chk({7'h0, pin}, 8'h01);
  endtask
  task s_ext;
    int k;
    op(1, 0, OFS_CMPA_LO, 8'h03);
    op(1, 0, OFS_CMPA_HI, 8'h00);
    for (int s = 0; s < 2; s++)
    begin
      k = 0;
      op(1, 0, OFS_CTRL0, 8'h00);
      op(1, 0, OFS_CTRL0, s ? 8'h78 : 8'h68);
      op(0, 0, 3'h0, 8'h00);
      go <= 1'b1;
      np <= 4'h3;
      @(posedge clk);
      go <= 1'b0;
      repeat (80)
      begin
        @(posedge clk);
        #1;
        k += (int_a === 1'b1);
      end
      chk(8'(k), 8'h01);
    end
  endtask
  task s_p;
    int n;
    logic p0;
    op(1, 0, OFS_CTRL0, 8'h00);
    op(1, 0, OFS_CTRL1, 8'hc0);
    op(1, 0, OFS_CTRL0, 8'h19);
    p0 = pin;
    cyc_to(1, n);
    cyc_to(1, n);
    chk(8'(n), 8'h7f);
    chk({7'h0, pin}, {7'h0, p0});
    op(1, 0, OFS_CTRL0, 8'h00);
    op(1, 0, OFS_CTRL0, 8'h09);
    cyc_to(1, n);
    cyc_to(1, n);
    chk(8'(n >> 1), 8'hff);
  endtask
  task s_pwm;
    int n;
    int k;
    k = 0;
    op(1, 0, OFS_CTRL0, 8'h00);
    op(1, 0, OFS_CMPA_LO, 8'h20);
    op(1, 0, OFS_CMPA_HI, 8'h00);
    op(1, 0, OFS_CTRL1, 8'ha8);
    rdc(OFS_CTRL1, 8'ha8);
    op(1, 0, OFS_CTRL0, 8'h19);
    cyc_to(1, n);
    repeat (128)
    begin
      @(posedge clk);
      #1;
      k += (pin === 1'b1);
    end
    chk(8'(k), 8'h20);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    s_regs;
    s_pair;
    s_cmp;
    s_ext;
    s_p;
    s_pwm;
    tally_and_finish;
  end
endmodule
`default_nettype wire
